// ---- common/mbr_pkg.sv ----
package mbr_pkg;

  // system clock of the user side and the fastest legal management clock
  localparam int CLK_HZ       = 20_000_000;
  localparam int MDC_MAX_HZ   = 5_000_000;
  // half period of the generated clock; two extra cycles cover the pin sync
  localparam int MDC_HALF_CYC =
    (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ) + 2;

  // frame layout, in bit times
  localparam int PRE_BITS     = 32;
  localparam int HDR_BITS     = 12;
  localparam int DATA_BITS    = 16;
  localparam int FRAME_BITS   = 64;
  localparam int TA_FIRST     = 46;
  localparam int DATA_FIRST   = 48;

  // start, opcodes and turnaround patterns
  localparam logic [1:0] START_PAT = 2'h1;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_BYTE   = 2'h0;
  localparam logic [1:0] OP_BAD    = 2'h3;
  localparam logic [1:0] TA_WRITE  = 2'h2;

  // address field bit that selects a byte read
  localparam int BYTE_RD_BIT = 4;

  // byte-wide configuration space and the indirect transceiver window
  localparam int         BYTE_REG_CNT  = 142;
  localparam logic [7:0] BYTE_REG_LAST = 8'h8D;
  localparam logic [3:0] PHY_WIN_HI    = 4'h9;

  // transceiver registers and their register indices
  localparam int         PHY_REG_CNT = 8;
  localparam logic [4:0] PHY_IDX [PHY_REG_CNT] =
    '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1D, 5'h1F};

  // reset values of the register storage
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [15:0] PHY_RST  = 16'h0000;

  typedef enum logic [2:0] {
    MBR_PRE   = 3'h0,
    MBR_START = 3'h1,
    MBR_HDR   = 3'h2,
    MBR_TA    = 3'h3,
    MBR_DATA  = 3'h4
  } mbr_dev_state_t;

  typedef enum logic [1:0] {
    MBR_IDLE = 2'h0,
    MBR_LOW  = 2'h1,
    MBR_HIGH = 2'h2
  } mbr_host_state_t;

endpackage

// ---- common/mbr_mgmt_if.sv ----
interface mbr_mgmt_if;

  logic mdc;
  logic host_mdio_o;
  logic host_mdio_oe;
  logic dev_mdio_o;
  logic dev_mdio_oe;
  logic mdio;

  // wire level: whoever enables drives, otherwise the pull-up holds one
  assign mdio = dev_mdio_oe  ? dev_mdio_o  :
                host_mdio_oe ? host_mdio_o : 1'b1;

  modport dev (
    input  mdc,
    input  mdio,
    output dev_mdio_o,
    output dev_mdio_oe
  );

  modport host (
    output mdc,
    output host_mdio_o,
    output host_mdio_oe,
    input  mdio
  );

endinterface

// ---- hw/mbr_dev.sv ----
module mbr_dev
  import mbr_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  mbr_mgmt_if.dev    mgmt,
  output logic       wr_valid,
  output logic       wr_std,
  output logic [7:0] wr_index,
  output logic [15:0] wr_data
);

  mbr_dev_state_t state_reg;
  logic [5:0]     cnt_reg;
  logic [11:0]    hdr_reg;
  logic [15:0]    dat_reg;
  logic [7:0]     byte_mem [BYTE_REG_CNT];
  logic [15:0]    phy_mem  [PHY_REG_CNT];
  logic           upd_tog_reg;
  logic           upd_std_reg;
  logic [7:0]     upd_idx_reg;
  logic [15:0]    upd_dat_reg;

  // decoded header fields
  logic [1:0]  op;
  logic [4:0]  phy_f;
  logic [4:0]  reg_f;
  logic        is_byte;
  logic        is_rd;
  logic [7:0]  byte_idx;
  logic        byte_hit;
  logic        win_hit;
  logic [2:0]  win_slot;
  logic        std_hit;
  logic [2:0]  std_slot;
  logic [15:0] rd_word;
  logic [15:0] wdata;
  logic        commit;

  assign op       = hdr_reg[11:10];
  assign phy_f    = hdr_reg[9:5];
  assign reg_f    = hdr_reg[4:0];
  assign is_byte  = (op == OP_BYTE);
  assign is_rd    = (op == OP_READ) ||
                    (is_byte && phy_f[BYTE_RD_BIT]);
  assign byte_idx = {phy_f[2:0], reg_f};
  assign byte_hit = (byte_idx <= BYTE_REG_LAST);
  assign win_hit  = (byte_idx[7:4] == PHY_WIN_HI);
  assign win_slot = byte_idx[3:1];
  assign wdata    = {dat_reg[14:0], mgmt.mdio};
  assign commit   = (state_reg == MBR_DATA) &&
                    (cnt_reg == 6'(DATA_BITS - 1)) && !is_rd;

  // look up the storage slot of a standard register index
  always_comb begin
    std_hit  = 1'b0;
    std_slot = 3'h0;
    for (int i = 0; i < PHY_REG_CNT; i++) begin
      if (PHY_IDX[i] == reg_f) begin
        std_hit  = 1'b1;
        std_slot = 3'(i);
      end
    end
  end

  // word returned by a read frame
  always_comb begin
    rd_word = 16'h0000;
    if (!is_byte && std_hit) begin
      rd_word = phy_mem[std_slot];
    end else if (is_byte && byte_hit) begin
      rd_word = {8'h00, byte_mem[byte_idx]};
    end else if (is_byte && win_hit) begin
      rd_word = {8'h00, byte_idx[0] ? phy_mem[win_slot][15:8]
                                    : phy_mem[win_slot][7:0]};
    end
  end

  // frame sequencer, sampling on the rising management clock edge
  always_ff @(posedge mgmt.mdc or posedge rst) begin
    if (rst) begin
      state_reg <= MBR_PRE;
      cnt_reg   <= 6'h00;
    end else begin
      case (state_reg)
        MBR_PRE: begin
          if (mgmt.mdio) begin
            if (cnt_reg != 6'(PRE_BITS)) begin
              cnt_reg <= cnt_reg + 6'h01;
            end
          end else if (cnt_reg == 6'(PRE_BITS)) begin
            state_reg <= MBR_START;
          end else begin
            cnt_reg <= 6'h00;
          end
        end
        MBR_START: begin
          cnt_reg <= 6'h00;
          if (mgmt.mdio == START_PAT[0]) begin
            state_reg <= MBR_HDR;
          end else begin
            state_reg <= MBR_PRE;
          end
        end
        MBR_HDR: begin
          if (cnt_reg == 6'h01 && {hdr_reg[0], mgmt.mdio} == OP_BAD) begin
            state_reg <= MBR_PRE;
            cnt_reg   <= 6'h00;
          end else if (cnt_reg == 6'(HDR_BITS - 1)) begin
            state_reg <= MBR_TA;
            cnt_reg   <= 6'h00;
          end else begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        MBR_TA: begin
          if (cnt_reg == 6'h01) begin
            state_reg <= MBR_DATA;
            cnt_reg   <= 6'h00;
          end else begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        MBR_DATA: begin
          if (cnt_reg == 6'(DATA_BITS - 1)) begin
            state_reg <= MBR_PRE;
            cnt_reg   <= 6'h00;
          end else begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        default: begin
          state_reg <= MBR_PRE;
          cnt_reg   <= 6'h00;
        end
      endcase
    end
  end

  // header capture, msb first
  always_ff @(posedge mgmt.mdc or posedge rst) begin
    if (rst) begin
      hdr_reg <= 12'h000;
    end else if (state_reg == MBR_HDR) begin
      hdr_reg <= {hdr_reg[10:0], mgmt.mdio};
    end
  end

  // data shifter: loads read word, collects write word
  always_ff @(posedge mgmt.mdc or posedge rst) begin
    if (rst) begin
      dat_reg <= 16'h0000;
    end else if (state_reg == MBR_TA && cnt_reg == 6'h01) begin
      dat_reg <= {rd_word[14:0], 1'b0};
    end else if (state_reg == MBR_DATA) begin
      dat_reg <= {dat_reg[14:0], mgmt.mdio && !is_rd};
    end
  end

  // line driver: zero in second turnaround bit, then data, then release
  always_ff @(posedge mgmt.mdc or posedge rst) begin
    if (rst) begin
      mgmt.dev_mdio_o  <= 1'b1;
      mgmt.dev_mdio_oe <= 1'b0;
    end else if (state_reg == MBR_TA && cnt_reg == 6'h00 && is_rd) begin
      mgmt.dev_mdio_o  <= 1'b0;
      mgmt.dev_mdio_oe <= 1'b1;
    end else if (state_reg == MBR_TA && cnt_reg == 6'h01 && is_rd) begin
      mgmt.dev_mdio_o  <= rd_word[15];
    end else if (state_reg == MBR_DATA && is_rd) begin
      mgmt.dev_mdio_o <= dat_reg[15];
      if (cnt_reg == 6'(DATA_BITS - 1)) begin
        mgmt.dev_mdio_oe <= 1'b0;
      end
    end else begin
      mgmt.dev_mdio_oe <= 1'b0;
    end
  end

  // byte-wide configuration storage
  always_ff @(posedge mgmt.mdc or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < BYTE_REG_CNT; i++) begin
        byte_mem[i] <= BYTE_RST;
      end
    end else if (commit && is_byte && byte_hit) begin
      byte_mem[byte_idx] <= wdata[7:0];
    end
  end

  // transceiver register storage, direct or through the byte window
  always_ff @(posedge mgmt.mdc or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PHY_REG_CNT; i++) begin
        phy_mem[i] <= PHY_RST;
      end
    end else if (commit && op == OP_WRITE && std_hit) begin
      phy_mem[std_slot] <= wdata;
    end else if (commit && is_byte && win_hit && byte_idx[0]) begin
      phy_mem[win_slot][15:8] <= wdata[7:0];
    end else if (commit && is_byte && win_hit) begin
      phy_mem[win_slot][7:0] <= wdata[7:0];
    end
  end

  // write notice held stable for the crossing to the user clock
  always_ff @(posedge mgmt.mdc or posedge rst) begin
    if (rst) begin
      upd_tog_reg <= 1'b0;
      upd_std_reg <= 1'b0;
      upd_idx_reg <= 8'h00;
      upd_dat_reg <= 16'h0000;
    end else if (commit && (op == OP_WRITE || is_byte)) begin
      upd_tog_reg <= ~upd_tog_reg;
      upd_std_reg <= !is_byte;
      upd_idx_reg <= is_byte ? byte_idx : {3'h0, reg_f};
      upd_dat_reg <= is_byte ? {8'h00, wdata[7:0]} : wdata;
    end
  end

  // toggle synchroniser, three stages, counted when stages two and three agree
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic tog_seen_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end else begin
      tog_s1_reg <= upd_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  // user-side write notice, one clock pulse per committed write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_seen_reg <= 1'b0;
      wr_valid     <= 1'b0;
      wr_std       <= 1'b0;
      wr_index     <= 8'h00;
      wr_data      <= 16'h0000;
    end else if (tog_s2_reg == tog_s3_reg && tog_s3_reg != tog_seen_reg) begin
      tog_seen_reg <= tog_s3_reg;
      wr_valid     <= 1'b1;
      wr_std       <= upd_std_reg;
      wr_index     <= upd_idx_reg;
      wr_data      <= upd_dat_reg;
    end else begin
      wr_valid <= 1'b0;
    end
  end

endmodule

// ---- hw/mbr_host.sv ----
module mbr_host
  import mbr_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  mbr_mgmt_if.host    mgmt,
  input  wire logic   req_valid,
  input  wire logic [1:0]  req_op,
  input  wire logic [4:0]  req_phy,
  input  wire logic [4:0]  req_reg,
  input  wire logic [15:0] req_wdata,
  output logic        req_ready,
  output logic        resp_valid,
  output logic [15:0] resp_rdata
);

  mbr_host_state_t state_reg;
  logic [3:0]      div_reg;
  logic [5:0]      bit_reg;
  logic [63:0]     frame_reg;
  logic            rd_reg;
  logic            s1_reg;
  logic            s2_reg;
  logic            s3_reg;
  logic            filt_reg;
  logic            req_rd;
  logic [63:0]     frame_next;
  logic            half_done;

  // read for opcode 10, or opcode 00 with address bit4 set
  assign req_rd = (req_op == OP_READ) ||
                  (req_op == OP_BYTE && req_phy[BYTE_RD_BIT]);
  // serial image, msb first; turnaround and data stay one while reading
  assign frame_next = {{PRE_BITS{1'b1}}, START_PAT, req_op, req_phy,
                       req_reg, req_rd ? 2'h3 : TA_WRITE,
                       req_rd ? 16'hFFFF : req_wdata};
  assign half_done  = (div_reg == 4'(MDC_HALF_CYC - 1));

  // data line input: three stages, taken when the last two agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg   <= 1'b1;
      s2_reg   <= 1'b1;
      s3_reg   <= 1'b1;
      filt_reg <= 1'b1;
    end else begin
      s1_reg <= mgmt.mdio;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        filt_reg <= s3_reg;
      end
    end
  end

  // clock divider and bit sequencer; line changes while the clock is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg         <= MBR_IDLE;
      div_reg           <= 4'h0;
      bit_reg           <= 6'h00;
      frame_reg         <= 64'h0;
      rd_reg            <= 1'b0;
      mgmt.mdc          <= 1'b0;
      mgmt.host_mdio_o  <= 1'b1;
      mgmt.host_mdio_oe <= 1'b0;
      req_ready         <= 1'b1;
      resp_valid        <= 1'b0;
      resp_rdata        <= 16'h0000;
    end else begin
      resp_valid <= 1'b0;
      case (state_reg)
        MBR_IDLE: begin
          if (req_valid) begin
            state_reg         <= MBR_LOW;
            req_ready         <= 1'b0;
            frame_reg         <= frame_next;
            rd_reg            <= req_rd;
            bit_reg           <= 6'h00;
            div_reg           <= 4'h0;
            mgmt.host_mdio_o  <= frame_next[63];
            mgmt.host_mdio_oe <= 1'b1;
          end
        end
        MBR_LOW: begin
          div_reg <= div_reg + 4'h1;
          if (half_done) begin
            state_reg <= MBR_HIGH;
            div_reg   <= 4'h0;
            mgmt.mdc  <= 1'b1;
            if (rd_reg && bit_reg >= 6'(DATA_FIRST)) begin
              resp_rdata <= {resp_rdata[14:0], filt_reg};
            end
          end
        end
        MBR_HIGH: begin
          div_reg <= div_reg + 4'h1;
          if (half_done) begin
            div_reg  <= 4'h0;
            mgmt.mdc <= 1'b0;
            if (bit_reg == 6'(FRAME_BITS - 1)) begin
              state_reg         <= MBR_IDLE;
              mgmt.host_mdio_oe <= 1'b0;
              req_ready         <= 1'b1;
              resp_valid        <= 1'b1;
            end else begin
              state_reg         <= MBR_LOW;
              bit_reg           <= bit_reg + 6'h01;
              frame_reg         <= {frame_reg[62:0], 1'b1};
              mgmt.host_mdio_o  <= frame_reg[62];
              mgmt.host_mdio_oe <= !(rd_reg &&
                                     bit_reg >= 6'(TA_FIRST - 1));
            end
          end
        end
        default: begin
          state_reg <= MBR_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- bench/mbr_mgmt_sva.sv ----
module mbr_mgmt_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic host_mdio_o,
  input wire logic host_mdio_oe,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe,
  input wire logic mdio
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [9:0] fc_reg;
  logic [7:0] dc_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // cycles since the host took the line, zero while it floats
  always_ff @(posedge clk or posedge rst) begin
    if (rst) fc_reg <= 10'h000;
    else if (!host_mdio_oe) fc_reg <= 10'h000;
    else fc_reg <= fc_reg + 10'h001;
  end

  // cycles for which the device has driven the line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) dc_reg <= 8'h00;
    else if (!dev_mdio_oe) dc_reg <= 8'h00;
    else dc_reg <= dc_reg + 8'h01;
  end

  sequence s_dev_zero;
    (dev_mdio_oe && !mdio) [*8];
  endsequence
  sequence s_mdc_high;
    mdc [*4] ##1 !mdc;
  endsequence

  property p_no_fight;
    !(dev_mdio_oe && host_mdio_oe);
  endproperty
  property p_ta_zero;
    $rose(dev_mdio_oe) |-> s_dev_zero;
  endproperty
  property p_turn;
    $rose(dev_mdio_oe) |-> !host_mdio_oe && !$past(host_mdio_oe, 2);
  endproperty
  property p_dev_len;
    $fell(dev_mdio_oe) |-> dc_reg >= 8'h87 && dc_reg <= 8'h89;
  endproperty
  property p_mdc_rate;
    $rose(mdc) |-> s_mdc_high;
  endproperty
  property p_mdc_low;
    $fell(mdc) |-> !mdc [*4];
  endproperty
  property p_host_chg;
    $changed(host_mdio_o) |-> !mdc;
  endproperty
  property p_dev_chg;
    $changed(dev_mdio_o) |-> mdc;
  endproperty
  property p_pre;
    host_mdio_oe && fc_reg < 10'h100 |-> host_mdio_o;
  endproperty
  property p_start;
    host_mdio_oe && fc_reg == 10'h104 |-> !host_mdio_o ##8 host_mdio_o;
  endproperty
  property p_wr_ta;
    host_mdio_oe && fc_reg == 10'h174 |-> host_mdio_o ##8 !host_mdio_o;
  endproperty

  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive the data line");
  a_ta_zero: assert property (p_ta_zero)
    else $error("device turnaround bit not zero");
  a_turn: assert property (p_turn)
    else $error("device drove before host let go");
  a_dev_len: assert property (p_dev_len)
    else $error("device drive span wrong");
  a_mdc_rate: assert property (p_mdc_rate)
    else $error("management clock high time wrong");
  a_mdc_low: assert property (p_mdc_low)
    else $error("management clock low time too short");
  a_host_chg: assert property (p_host_chg)
    else $error("host changed line while clock high");
  a_dev_chg: assert property (p_dev_chg)
    else $error("device changed line while clock low");
  a_pre: assert property (p_pre)
    else $error("preamble bit not one");
  a_start: assert property (p_start)
    else $error("start pattern wrong");
  a_wr_ta: assert property (p_wr_ta)
    else $error("write turnaround wrong");
endmodule

// ---- bench/tb_top.sv ----
module tb_top;
  import mbr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk;
  logic        rst;
  logic        req_valid;
  logic [1:0]  req_op;
  logic [4:0]  req_phy;
  logic [4:0]  req_reg;
  logic [15:0] req_wdata;
  logic        req_ready;
  logic        resp_valid;
  logic [15:0] resp_rdata;
  logic        wr_valid;
  logic        wr_std;
  logic [7:0]  wr_index;
  logic [15:0] wr_data;
  logic [15:0] rd;
  logic        wr_s;
  logic [7:0]  wr_i;
  logic [15:0] wr_d;
  int          n_wr;
  int          fail_count;
  int          n_tests;

  mbr_mgmt_if u_mbr_mgmt_if ();
  mbr_dev u_mbr_dev (.clk(clk), .rst(rst), .mgmt(u_mbr_mgmt_if),
    .wr_valid(wr_valid), .wr_std(wr_std), .wr_index(wr_index),
    .wr_data(wr_data));
  mbr_host u_mbr_host (.clk(clk), .rst(rst), .mgmt(u_mbr_mgmt_if),
    .req_valid(req_valid), .req_op(req_op), .req_phy(req_phy),
    .req_reg(req_reg), .req_wdata(req_wdata), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata));
  mbr_mgmt_sva u_mbr_mgmt_sva (.clk(clk), .rst(rst),
    .mdc(u_mbr_mgmt_if.mdc), .host_mdio_o(u_mbr_mgmt_if.host_mdio_o),
    .host_mdio_oe(u_mbr_mgmt_if.host_mdio_oe),
    .dev_mdio_o(u_mbr_mgmt_if.dev_mdio_o),
    .dev_mdio_oe(u_mbr_mgmt_if.dev_mdio_oe), .mdio(u_mbr_mgmt_if.mdio));

  // user clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // latch every write notice of the device
  always @(posedge clk) begin
    if (rst) n_wr <= 0;
    else if (wr_valid === 1'b1) begin
      n_wr <= n_wr + 1;
      wr_s <= wr_std;
      wr_i <= wr_index;
      wr_d <= wr_data;
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one frame: hand over the request, wait for the end, let notices land
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] rg, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req_op <= op;
    req_phy <= phy;
    req_reg <= rg;
    req_wdata <= wd;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    chk("req_ready", 16'h0000, {15'h0000, req_ready});
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (resp_valid !== 1'b1 && n < 600);
    chk("resp_valid", 16'h0001, {15'h0000, resp_valid});
    chk("req_ready", 16'h0001, {15'h0000, req_ready});
    rd = resp_rdata;
    repeat (8) @(posedge clk);
  endtask

  task automatic t_std();
    for (int i = 0; i < PHY_REG_CNT; i++) begin
      xfer(OP_WRITE, 5'h01, PHY_IDX[i], 16'hA500 | 16'(i));
      chk("wr_meta", {8'h01, 3'h0, PHY_IDX[i]}, {7'h00, wr_s, wr_i});
      chk("wr_data", 16'hA500 | 16'(i), wr_d);
    end
    for (int i = 0; i < PHY_REG_CNT; i++) begin
      xfer(OP_READ, 5'h1E, PHY_IDX[i], 16'h0000);
      chk("std_rd", 16'hA500 | 16'(i), rd);
    end
    xfer(OP_WRITE, 5'h01, 5'h06, 16'hFFFF);
    xfer(OP_READ, 5'h01, 5'h06, 16'h0000);
    chk("std_gap", 16'h0000, rd);
    $display("test std done");
  endtask

  // byte write with junk upper byte and bit3 set, read back with bit3 clear
  task automatic t_byte(input logic [7:0] idx, input logic [7:0] b,
                        input logic [15:0] e);
    xfer(OP_BYTE, {2'h1, idx[7:5]}, idx[4:0], {8'hC3, b});
    chk("wr_meta", {8'h00, idx}, {7'h00, wr_s, wr_i});
    chk("wr_data", {8'h00, b}, wr_d);
    xfer(OP_BYTE, {2'h2, idx[7:5]}, idx[4:0], 16'h0000);
    chk("byte_rd", e, rd);
  endtask

  task automatic t_bytes();
    t_byte(8'h00, 8'h11, 16'h0011);
    t_byte(8'h47, 8'hE2, 16'h00E2);
    t_byte(8'h8D, 8'h7C, 16'h007C);
    t_byte(8'h8E, 8'h99, 16'h0000);
    $display("test byte done");
  endtask

  task automatic t_win();
    xfer(OP_WRITE, 5'h00, 5'h1D, 16'h1234);
    xfer(OP_BYTE, 5'h14, 5'h1D, 16'h0000);
    chk("win_rd", 16'h0012, rd);
    t_byte(8'h9E, 8'h5A, 16'h005A);
    xfer(OP_READ, 5'h00, 5'h1F, 16'h0000);
    chk("win_wr", 16'hA55A, rd);
    $display("test window done");
  endtask

  task automatic t_bad();
    int n0;
    n0 = n_wr;
    xfer(OP_BAD, 5'h00, 5'h00, 16'hFFFF);
    chk("notices", 16'(n0), 16'(n_wr));
    xfer(OP_READ, 5'h00, 5'h00, 16'h0000);
    chk("bad_rd", 16'hA500, rd);
    $display("test bad opcode done");
  endtask

  // reset in mid-run clears both register stores back to zero
  task automatic t_rst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    xfer(OP_READ, 5'h00, 5'h00, 16'h0000);
    chk("rst_std", 16'h0000, rd);
    xfer(OP_BYTE, 5'h10, 5'h00, 16'h0000);
    chk("rst_byte", 16'h0000, rd);
    $display("test reset done");
  endtask

  // main sequence
  initial begin
    rst = 1'b0;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_phy = 5'h00;
    req_reg = 5'h00;
    req_wdata = 16'h0000;
    fail_count = 0;
    n_tests = 0;
    #1;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_std();
    t_bytes();
    t_win();
    t_bad();
    t_rst();
    complete_run();
  end

  // watchdog, about three times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("ERROR watchdog expected finish seen hang");
    complete_run();
  end
endmodule
